// [hdl/gct_pkg.sv]
// Package for the gated sixteen-bit counter: register map, field positions and carriers.
// Assumes a 32-bit Avalon-MM register bus with word addressing in bytes.
package gct_pkg;

  // ==========================================================================
  // Register byte offsets.
  // ==========================================================================
  localparam logic [3:0] GCT_OFF_COUNT_LOW = 4'h0;
  localparam logic [3:0] GCT_OFF_COUNT_HIGH = 4'h4;
  localparam logic [3:0] GCT_OFF_COUNTER_CTRL = 4'h8;
  localparam logic [3:0] GCT_OFF_GATE_CTRL = 4'hC;

  // ==========================================================================
  // Counter control register fields.
  // ==========================================================================
  localparam int GCT_CC_ON = 0;
  localparam int GCT_CC_SYNC_BYPASS = 2;
  localparam int GCT_CC_OSC_EN = 3;
  localparam int GCT_CC_CLK_SEL_LO = 6;
  localparam int GCT_CC_OVF_FLAG = 8;
  localparam int GCT_CC_OVF_IE = 9;
  localparam int GCT_CC_GATE_FLAG = 10;
  localparam int GCT_CC_GATE_IE = 11;
  localparam int GCT_CC_PERIPH_IE = 12;
  localparam int GCT_CC_GLOBAL_IE = 13;
  localparam int GCT_CC_SLEEP = 14;

  // ==========================================================================
  // Gate control register fields.
  // ==========================================================================
  localparam int GCT_GC_SRC_LO = 0;
  localparam int GCT_GC_LEVEL = 2;
  localparam int GCT_GC_GO = 3;
  localparam int GCT_GC_SPM = 4;
  localparam int GCT_GC_TOGGLE = 5;
  localparam int GCT_GC_POL = 6;
  localparam int GCT_GC_ENABLE = 7;

  // ==========================================================================
  // Encodings and reset values.
  // ==========================================================================
  localparam logic [1:0] GCT_SRC_PIN = 2'h0;
  localparam logic [1:0] GCT_SRC_WRAP = 2'h1;
  localparam logic [1:0] GCT_SRC_CMP1 = 2'h2;
  localparam logic [1:0] GCT_SRC_CMP2 = 2'h3;
  localparam logic [1:0] GCT_CLK_EXT = 2'h2;
  localparam logic [15:0] GCT_COUNT_RST = 16'h0000;
  localparam logic [15:0] GCT_COUNT_TOP = 16'hFFFF;
  localparam logic [31:0] GCT_UNMAPPED_DATA = 32'h0000_0000;

  // Raw gate sources, grouped as they arrive.
  typedef struct packed {
    logic cmp2;
    logic cmp1;
    logic wrap;
    logic pin;
  } gct_gate_src_t;

endpackage

// [hdl/gct_gate.sv]
// Gate unit of the gated counter: source select, polarity, toggle, single pulse.
// Assumes all source inputs are already synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none
module gct_gate
  import gct_pkg::*;
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Sources and configuration.
  input wire gct_gate_src_t src_i,
  input wire logic [1:0] sel_i,
  input wire logic pol_i,
  input wire logic toggle_i,
  input wire logic spm_i,
  input wire logic go_i,
  // Results.
  output logic level_o,
  output logic go_clear_o
);

  // ==========================================================================
  // Source selection and polarity.
  // ==========================================================================
  // Selected raw source.
  wire logic sel_src;
  assign sel_src = src_i[sel_i];
  // Polarity turns the active level into a high level.
  wire logic pol_src;
  assign pol_src = sel_src ~^ pol_i;
  logic pol_src_r; // Previous polarity-corrected source.
  logic tog_r; // Toggle stage flip-flop.
  logic spm_arm_r; // Single pulse: counting window is open.
  wire logic src_rise;
  assign src_rise = pol_src & ~pol_src_r;

  // Toggle stage feeds the single-pulse stage when both are on.
  wire logic stage1;
  assign stage1 = toggle_i ? tog_r : pol_src;
  logic stage1_r;
  wire logic s1_rise;
  assign s1_rise = stage1 & ~stage1_r;
  wire logic s1_fall;
  assign s1_fall = ~stage1 & stage1_r;

  // Previous-value and toggle flip-flops.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pol_src_r <= 1'b0;
      tog_r <= 1'b0;
      stage1_r <= 1'b0;
    end else begin
      pol_src_r <= pol_src;
      stage1_r <= stage1;
      // Held clear while toggle is off so the measured edge is known.
      if (!toggle_i) begin
        tog_r <= 1'b0;
      end else if (src_rise) begin
        tog_r <= ~tog_r;
      end
    end
  end

  // Single-pulse window opens on a rising edge while go is set and closes on
  // the trailing edge; the go bit is then cleared so nothing reopens it.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      spm_arm_r <= 1'b0;
    end else if (!spm_i || !go_i) begin
      spm_arm_r <= 1'b0;
    end else if (s1_rise && !spm_arm_r) begin
      spm_arm_r <= 1'b1;
    end else if (s1_fall) begin
      spm_arm_r <= 1'b0;
    end
  end

  assign level_o = spm_i ? (spm_arm_r & stage1) : stage1;
  assign go_clear_o = spm_i & go_i & spm_arm_r & s1_fall;

endmodule
`default_nettype wire

// [hdl/gct_top.sv]
// Gated sixteen-bit counter with Avalon-MM register access.
// Assumes a 10 MHz clk_i; pins and the external count clock are asynchronous.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - Bypass bit: external clock edges counted unsynchronised; code still uses the two-flop synchroniser, skips only retiming
// - Async external mode keeps counting in sleep
// - Mode switching may drop or add increments
// - Byte reads valid under asynchronous external clock
// - Gate enable qualifies counting; polarity picks level
// - Gated count only while gate level active
// - Two-bit field selects gate source
// - Eight-bit timer wrap pulse is gate source
// - Toggle flip-flop flips on each gate edge; here only on rising edges of the polarity-corrected source
// - Toggle off forces toggle flip-flop clear
// - Go bit arms; trailing edge clears go
// - No counting after acquisition until go again
// - Toggle and single pulse operate in series
// - Gate level status readable, even ungated
// - Falling gate level sets gate event flag
// - Gate event flag works without gate enable
// - Counter rollover sets overflow flag
// - Overflow interrupt needs four enables; flag sticky
// - Sleep counting only async external; overflow wakes
// - Crystal oscillator enable held through sleep
// - Counter counts only with counter-on set
// - Counter byte write clears prescale counter
module gct_top
  import gct_pkg::*;
#(
  parameter int PRESCALE_W = 3
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Avalon-MM slave.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // External count clock and gate sources, all asynchronous.
  input wire logic external_count_clock_pin_i,
  input wire logic gate_pin_i,
  input wire logic eight_bit_timer_wrap_pulse_i,
  input wire logic comparator_one_out_i,
  input wire logic comparator_two_out_i,
  // Events toward the processor.
  output logic irq_o,
  output logic wake_o,
  output logic crystal_osc_enable_o
);

  // ==========================================================================
  // Elaboration check.
  // ==========================================================================
  if (PRESCALE_W < 3 || PRESCALE_W > 8) begin : g_bad_prescale
    $error("PRESCALE_W must lie between 3 and 8.");
  end

  // ==========================================================================
  // Input synchronisers.
  // ==========================================================================
  // Five asynchronous inputs each pass two flip-flops; the first stage is
  // read only by the second.
  localparam int NSYNC = 5;
  wire logic [NSYNC-1:0] raw_in;
  assign raw_in = {comparator_two_out_i, comparator_one_out_i,
                   eight_bit_timer_wrap_pulse_i, gate_pin_i,
                   external_count_clock_pin_i};
  logic [NSYNC-1:0] meta_r;
  logic [NSYNC-1:0] sync_r;
  for (genvar i = 0; i < NSYNC; i++) begin : g_sync
    // Two-stage synchroniser for one input.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        meta_r[i] <= 1'b0;
        sync_r[i] <= 1'b0;
      end else begin
        meta_r[i] <= raw_in[i];
        sync_r[i] <= meta_r[i];
      end
    end
  end

  // ==========================================================================
  // Control state.
  // ==========================================================================
  logic [15:0] count_r; // Sixteen-bit count.
  logic [PRESCALE_W-1:0] presc_r; // Hidden prescale counter.
  logic [1:0] presc_sel_r; // Prescale ratio select, 1/2/4/8.
  logic counter_on_r;
  logic sync_bypass_r;
  logic crystal_osc_enable_r;
  logic [1:0] count_clock_select_r;
  logic overflow_flag_r;
  logic overflow_irq_enable_r;
  logic gate_event_flag_r;
  logic gate_event_irq_enable_r;
  logic peripheral_irq_enable_r;
  logic global_irq_enable_r;
  logic sleep_r; // Processor sleep indication written by software model.
  logic gate_enable_r;
  logic gate_polarity_r;
  logic gate_toggle_mode_r;
  logic gate_single_pulse_mode_r;
  logic acquisition_go_r;
  logic [1:0] gate_source_select_r;
  logic gate_level_r; // Registered gate level status.
  logic ext_clk_r; // Previous sampled external clock.
  logic [31:0] rdata_r;
  logic wait_r;
  logic irq_r;
  logic wake_r;

  // ==========================================================================
  // Gate unit.
  // ==========================================================================
  wire gct_gate_src_t gate_src;
  assign gate_src = '{cmp2: sync_r[4], cmp1: sync_r[3], wrap: sync_r[2],
                      pin: sync_r[1]};
  wire logic gate_level;
  wire logic go_clear;
  gct_gate u_gate (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .src_i(gate_src),
    .sel_i(gate_source_select_r),
    .pol_i(gate_polarity_r),
    .toggle_i(gate_toggle_mode_r),
    .spm_i(gate_single_pulse_mode_r),
    .go_i(acquisition_go_r),
    .level_o(gate_level),
    .go_clear_o(go_clear)
  );

  // ==========================================================================
  // Count clock and increment decode.
  // ==========================================================================
  // The bypass path counts on the sampled edge without the extra retiming
  // register; either way the counter stays in clk_i so reads stay coherent.
  wire logic ext_sel;
  assign ext_sel = (count_clock_select_r == GCT_CLK_EXT);
  wire logic ext_rise;
  assign ext_rise = sync_r[0] & ~ext_clk_r;
  logic ext_rise_r;
  wire logic ext_tick;
  assign ext_tick = sync_bypass_r ? ext_rise : ext_rise_r;
  // In sleep only the asynchronous external mode may tick.
  wire logic sleep_ok;
  assign sleep_ok = !sleep_r || (ext_sel && sync_bypass_r);
  wire logic src_tick;
  assign src_tick = (ext_sel ? ext_tick : 1'b1) & sleep_ok;
  // Gate qualifies counting only when gate enable is set.
  wire logic gate_ok;
  assign gate_ok = !gate_enable_r || gate_level;
  wire logic run;
  assign run = counter_on_r & gate_ok;
  // Prescaler terminal count for 1, 2, 4 or 8.
  wire logic [PRESCALE_W-1:0] presc_mask;
  assign presc_mask = PRESCALE_W'((1 << presc_sel_r) - 1);
  wire logic presc_done;
  assign presc_done = ((presc_r & presc_mask) == presc_mask);
  wire logic inc;
  assign inc = run & src_tick & presc_done;
  wire logic rollover;
  assign rollover = inc && (count_r == GCT_COUNT_TOP);
  wire logic gate_fall;
  assign gate_fall = gate_level_r & ~gate_level;

  // ==========================================================================
  // Bus decode.
  // ==========================================================================
  wire logic wr_low;
  assign wr_low = avs_write_i && wait_r == 1'b0 && avs_address_i == GCT_OFF_COUNT_LOW
                  && avs_byteenable_i[0];
  wire logic wr_high;
  assign wr_high = avs_write_i && !wait_r && avs_address_i == GCT_OFF_COUNT_HIGH
                   && avs_byteenable_i[0];
  wire logic wr_cc;
  assign wr_cc = avs_write_i && !wait_r && avs_address_i == GCT_OFF_COUNTER_CTRL;
  wire logic wr_gc;
  assign wr_gc = avs_write_i && !wait_r && avs_address_i == GCT_OFF_GATE_CTRL
                 && avs_byteenable_i[0];
  wire logic [31:0] cc_view;
  assign cc_view = {17'h0, sleep_r, global_irq_enable_r, peripheral_irq_enable_r,
                    gate_event_irq_enable_r, gate_event_flag_r, overflow_irq_enable_r,
                    overflow_flag_r, count_clock_select_r, presc_sel_r,
                    crystal_osc_enable_r, sync_bypass_r, 1'b0, counter_on_r};
  wire logic [31:0] gc_view;
  assign gc_view = {24'h0, gate_enable_r, gate_polarity_r, gate_toggle_mode_r,
                    gate_single_pulse_mode_r, acquisition_go_r,
                    gate_level_r, gate_source_select_r};
  wire logic [31:0] rd_mux;
  assign rd_mux = (avs_address_i == GCT_OFF_COUNT_LOW) ? {24'h0, count_r[7:0]} :
                  (avs_address_i == GCT_OFF_COUNT_HIGH) ? {24'h0, count_r[15:8]} :
                  (avs_address_i == GCT_OFF_COUNTER_CTRL) ? cc_view :
                  (avs_address_i == GCT_OFF_GATE_CTRL) ? gc_view : GCT_UNMAPPED_DATA;

  // ==========================================================================
  // Bus handshake: one wait state, answer on the second edge.
  // ==========================================================================
  // Read data is captured from the registers in clk_i, so no torn byte
  // is ever seen even with an asynchronous external clock.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= GCT_UNMAPPED_DATA;
    end else begin
      wait_r <= !(wait_r && (avs_read_i || avs_write_i));
      if (avs_read_i && wait_r) begin
        rdata_r <= rd_mux;
      end
    end
  end

  // ==========================================================================
  // Counter and prescaler.
  // ==========================================================================
  // A byte write wins over an increment in the same cycle; software is
  // expected to stop the counter first, so this only matters for misuse.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_r <= GCT_COUNT_RST;
      presc_r <= '0;
      ext_clk_r <= 1'b0;
      ext_rise_r <= 1'b0;
    end else begin
      ext_clk_r <= sync_r[0];
      ext_rise_r <= ext_rise;
      if (wr_low || wr_high) begin
        presc_r <= '0;
        if (wr_low) begin
          count_r[7:0] <= avs_writedata_i[7:0];
        end else begin
          count_r[15:8] <= avs_writedata_i[7:0];
        end
      end else if (run && src_tick) begin
        presc_r <= presc_done ? '0 : presc_r + 1'b1;
        if (inc) begin
          count_r <= count_r + 16'h0001;
        end
      end
    end
  end

  // ==========================================================================
  // Control registers.
  // ==========================================================================
  // Hardware sets of the sticky flags win over a software clear.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      counter_on_r <= 1'b0;
      sync_bypass_r <= 1'b0;
      crystal_osc_enable_r <= 1'b0;
      count_clock_select_r <= 2'h0;
      presc_sel_r <= 2'h0;
      overflow_flag_r <= 1'b0;
      overflow_irq_enable_r <= 1'b0;
      gate_event_flag_r <= 1'b0;
      gate_event_irq_enable_r <= 1'b0;
      peripheral_irq_enable_r <= 1'b0;
      global_irq_enable_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      if (wr_cc) begin
        if (avs_byteenable_i[0]) begin
          counter_on_r <= avs_writedata_i[GCT_CC_ON];
          sync_bypass_r <= avs_writedata_i[GCT_CC_SYNC_BYPASS];
          crystal_osc_enable_r <= avs_writedata_i[GCT_CC_OSC_EN];
          presc_sel_r <= avs_writedata_i[5:4];
          count_clock_select_r <= avs_writedata_i[GCT_CC_CLK_SEL_LO +: 2];
        end
        if (avs_byteenable_i[1]) begin
          overflow_flag_r <= avs_writedata_i[GCT_CC_OVF_FLAG] | rollover;
          overflow_irq_enable_r <= avs_writedata_i[GCT_CC_OVF_IE];
          gate_event_flag_r <= avs_writedata_i[GCT_CC_GATE_FLAG] | gate_fall;
          gate_event_irq_enable_r <= avs_writedata_i[GCT_CC_GATE_IE];
          peripheral_irq_enable_r <= avs_writedata_i[GCT_CC_PERIPH_IE];
          global_irq_enable_r <= avs_writedata_i[GCT_CC_GLOBAL_IE];
          sleep_r <= avs_writedata_i[GCT_CC_SLEEP];
        end else begin
          overflow_flag_r <= overflow_flag_r | rollover;
          gate_event_flag_r <= gate_event_flag_r | gate_fall;
        end
      end else begin
        overflow_flag_r <= overflow_flag_r | rollover;
        gate_event_flag_r <= gate_event_flag_r | gate_fall;
        // Overflow wakes the processor from sleep.
        if (sleep_r && rollover) begin
          sleep_r <= 1'b0;
        end
      end
    end
  end

  // Gate control register; the go bit is cleared by hardware and a
  // hardware clear takes priority over a simultaneous software write.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      gate_enable_r <= 1'b0;
      gate_polarity_r <= 1'b0;
      gate_toggle_mode_r <= 1'b0;
      gate_single_pulse_mode_r <= 1'b0;
      acquisition_go_r <= 1'b0;
      gate_source_select_r <= GCT_SRC_PIN;
      gate_level_r <= 1'b0;
    end else begin
      gate_level_r <= gate_level;
      if (wr_gc) begin
        gate_enable_r <= avs_writedata_i[GCT_GC_ENABLE];
        gate_polarity_r <= avs_writedata_i[GCT_GC_POL];
        gate_toggle_mode_r <= avs_writedata_i[GCT_GC_TOGGLE];
        gate_single_pulse_mode_r <= avs_writedata_i[GCT_GC_SPM];
        gate_source_select_r <= avs_writedata_i[GCT_GC_SRC_LO +: 2];
      end
      if (go_clear) begin
        acquisition_go_r <= 1'b0;
      end else if (wr_gc) begin
        acquisition_go_r <= avs_writedata_i[GCT_GC_GO];
      end
    end
  end

  // ==========================================================================
  // Interrupt and wake outputs.
  // ==========================================================================
  // Overflow needs counter-on and all three enables; the gate event needs
  // its own enable plus the peripheral and global enables.
  wire logic ovf_irq;
  assign ovf_irq = overflow_flag_r & counter_on_r & overflow_irq_enable_r
                   & peripheral_irq_enable_r & global_irq_enable_r;
  wire logic gate_irq;
  assign gate_irq = gate_event_flag_r & gate_event_irq_enable_r
                    & peripheral_irq_enable_r & global_irq_enable_r;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_r <= 1'b0;
      wake_r <= 1'b0;
    end else begin
      irq_r <= ovf_irq | gate_irq;
      wake_r <= sleep_r & rollover & overflow_irq_enable_r & peripheral_irq_enable_r;
    end
  end

  assign irq_o = irq_r;
  assign wake_o = wake_r;
  assign crystal_osc_enable_o = crystal_osc_enable_r;
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;

endmodule
`default_nettype wire

// [verif/gct_far_model.sv]
// Far side of the counter: external count clock and the raw gate sources.
// Assumes the bench sets the source levels and starts and stops the clock.
`timescale 1ns/1ns
`default_nettype none
module gct_far_model
  import gct_pkg::*;
(
  // Control from the bench.
  input wire logic run_i,
  input wire gct_gate_src_t lvl_i,
  // Pins toward the counter.
  output var logic ext_clk_o,
  output var gct_gate_src_t src_o,
  output var int edges_o
);
  // The sources simply follow the levels that the bench asks for.
  assign src_o = lvl_i;
  // ==========
  // The clock stands low between bursts, so every burst is whole periods.
  initial begin
    ext_clk_o = 1'b0;
    edges_o = 0;
    #37;
    forever begin
      wait (run_i);
      #400 ext_clk_o = 1'b1;
      edges_o = edges_o + 1;
      #400 ext_clk_o = 1'b0;
    end
  end
endmodule
`default_nettype wire

// [verif/gct_top_monitor.sv]
// Checker for gct_top: bus handshake, read data and event outputs.
// Assumes one clock domain; bound to every gct_top instance.
`timescale 1ns/1ns
`default_nettype none
module gct_top_monitor
  import gct_pkg::*;
#(
  parameter int PRESCALE_W = 3
)
(
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Bus and event outputs.
  input wire logic [3:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic irq_o,
  input wire logic wake_o,
  input wire logic crystal_osc_enable_o
);
  // A write lands at the edge that sees waitrequest low.
  wire logic wr_w = avs_write_i && !avs_waitrequest_o;
  wire logic rd_w = avs_read_i && !avs_waitrequest_o;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // Handshake and read data.
  wait_drop_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
    |=> !avs_waitrequest_o) else $error("no answer one edge after a request");
  wait_one_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  wait_cause_a: assert property (!avs_waitrequest_o |-> $past(avs_read_i || avs_write_i))
    else $error("answer without a request");
  rdata_hold_a: assert property ($changed(avs_readdata_o) |-> $past(avs_read_i))
    else $error("read data moved without a read");
  byte_width_a: assert property (rd_w && !avs_address_i[3] |-> avs_readdata_o[31:8] == 24'h0)
    else $error("counter byte read wider than a byte");
  unmapped_zero_a: assert property (rd_w && avs_address_i[1:0] != 2'h0
    |-> avs_readdata_o == GCT_UNMAPPED_DATA) else $error("unmapped read not zero");
  // ==========
  // Events: a sticky flag only clears, and the enables only change, through writes.
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_w) || $past(wr_w, 2) || $past(wr_w, 3))
    else $error("interrupt dropped without a write");
  wake_pulse_a: assert property (wake_o |=> (!wake_o) [*4])
    else $error("wake is not a single pulse");
  osc_keep_a: assert property ($changed(crystal_osc_enable_o) |-> $past(wr_w) || $past(wr_w, 2))
    else $error("oscillator enable moved without a write");
  cover property (rd_w);
  cover property ($rose(irq_o));
  cover property (wake_o);
endmodule
bind gct_top gct_top_monitor #(.PRESCALE_W(PRESCALE_W)) mon (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
  .wake_o(wake_o), .crystal_osc_enable_o(crystal_osc_enable_o));
`default_nettype wire

// [verif/test_gated_counter_sixteen_bit.sv]
// Bench for gct_top: registers, gating, prescale, overflow, wake and single pulse.
// Assumes gct_far_model drives the count clock and the gate sources.
`timescale 1ns/1ns
`default_nettype none
module test_gated_counter_sixteen_bit
  import gct_pkg::*;
;
  typedef struct packed {
    logic [31:0] gc;
    gct_gate_src_t lv;
    logic [15:0] inc;
  } gct_row_t;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [3:0] adr = 4'h0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic run = 1'b0;
  logic wake_seen = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rq;
  gct_gate_src_t lvl = 4'h0;
  gct_gate_src_t src;
  wire logic [31:0] rdat;
  wire logic ext_clk, irq, wake, osc, wait_o;
  int edges;
  int bad_count = 0;
  int samples_checked = 0;
  // Gate setting, source levels, increments expected from four edges.
  gct_row_t rows [7] = '{{32'hC0, 4'h1, 16'h4}, {32'hC0, 4'h0, 16'h0}, {32'h80, 4'h0, 16'h4},
    {32'hC1, 4'h2, 16'h4}, {32'hC2, 4'h4, 16'h4}, {32'hC3, 4'h4, 16'h0}, {32'h0, 4'h0, 16'h4}};
  always #50 clk_i = ~clk_i;
  always @(posedge clk_i) if (wake === 1'b1) wake_seen <= 1'b1;
  gct_top #(.PRESCALE_W(3)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wait_o), .external_count_clock_pin_i(ext_clk),
    .gate_pin_i(src.pin), .eight_bit_timer_wrap_pulse_i(src.wrap),
    .comparator_one_out_i(src.cmp1), .comparator_two_out_i(src.cmp2), .irq_o(irq),
    .wake_o(wake), .crystal_osc_enable_o(osc));
  gct_far_model far (.run_i(run), .lvl_i(lvl), .ext_clk_o(ext_clk), .src_o(src), .edges_o(edges));
  // ==========
  // Compare, bus cycle and count helpers.
  task chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    if (wait_o !== 1'b0) bad_count++;
    rq = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task cnt(input logic [15:0] e);
    logic [7:0] lo;
    bus(1'b0, GCT_OFF_COUNT_LOW, 32'h0);
    lo = rq[7:0];
    bus(1'b0, GCT_OFF_COUNT_HIGH, 32'h0);
    chk({16'h0, rq[7:0], lo}, {16'h0, e});
  endtask
  // The counter is stopped before its bytes are written.
  task load(input logic [15:0] v);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h0);
    bus(1'b1, GCT_OFF_COUNT_LOW, {24'h0, v[7:0]});
    bus(1'b1, GCT_OFF_COUNT_HIGH, {24'h0, v[15:8]});
  endtask
  // Sources settle first; the count clock then runs for n whole periods.
  task pulses(input int n);
    int t;
    t = edges + n;
    repeat (10) @(posedge clk_i);
    run <= 1'b1;
    while (edges < t) @(posedge clk_i);
    run <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (30000) @(posedge clk_i);
    bad_count++;
    final_report();
  end
  // ==========
  // Main sequence.
  initial begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    bus(1'b0, GCT_OFF_COUNTER_CTRL, 32'h0);
    chk(rq, 32'h0);
    cnt(16'h0);
    bus(1'b1, 4'h2, 32'hFFFF_FFFF);
    bus(1'b0, 4'h2, 32'h0);
    chk(rq, 32'h0);
    foreach (rows[i]) begin
      load(16'h0);
      bus(1'b1, GCT_OFF_GATE_CTRL, rows[i].gc);
      bus(1'b0, GCT_OFF_GATE_CTRL, 32'h0);
      chk(rq & 32'hFB, rows[i].gc);
      bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h81);
      lvl <= rows[i].lv;
      pulses(4);
      cnt(rows[i].inc);
    end
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h80);
    pulses(4);
    cnt(16'h4);
    load(16'h0);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h91);
    pulses(3);
    cnt(16'h1);
    load(16'h0);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h91);
    pulses(1);
    cnt(16'h0);
    load(16'hFFFF);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h3281);
    pulses(1);
    cnt(16'h0);
    chk(32'(irq), 32'h1);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h1381);
    repeat (4) @(posedge clk_i);
    chk(32'(irq), 32'h0);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h3381);
    repeat (4) @(posedge clk_i);
    chk(32'(irq), 32'h1);
    load(16'hFFFF);
    wake_seen <= 1'b0;
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h528D);
    @(posedge clk_i);
    chk(32'(osc), 32'h1);
    pulses(1);
    chk(32'(wake_seen), 32'h1);
    chk(32'(irq), 32'h0);
    chk(32'(osc), 32'h1);
    cnt(16'h0);
    load(16'h0);
    bus(1'b1, GCT_OFF_GATE_CTRL, 32'hD8);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h81);
    lvl <= 4'h1;
    pulses(3);
    lvl <= 4'h0;
    repeat (10) @(posedge clk_i);
    bus(1'b0, GCT_OFF_GATE_CTRL, 32'h0);
    chk(rq & 32'h8, 32'h0);
    bus(1'b0, GCT_OFF_COUNTER_CTRL, 32'h0);
    chk(rq & 32'h400, 32'h400);
    lvl <= 4'h1;
    pulses(3);
    lvl <= 4'h0;
    cnt(16'h3);
    bus(1'b1, GCT_OFF_GATE_CTRL, 32'h0);
    bus(1'b0, GCT_OFF_GATE_CTRL, 32'h0);
    chk(rq & 32'h4, 32'h4);
    load(16'h0);
    bus(1'b1, GCT_OFF_GATE_CTRL, 32'hE0);
    bus(1'b1, GCT_OFF_COUNTER_CTRL, 32'h81);
    lvl <= 4'h1;
    repeat (8) @(posedge clk_i);
    lvl <= 4'h0;
    pulses(2);
    cnt(16'h2);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    cnt(16'h0);
    final_report();
  end
endmodule
`default_nettype wire
